/* rtl/sleep_wakeup_cfg.svh */
`ifndef SLEEP_WAKEUP_CFG_SVH
`define SLEEP_WAKEUP_CFG_SVH

// Register offsets (byte addresses)
`define SWC_CTRL_OFS        4'h0
`define SWC_STATUS_OFS      4'h4
`define SWC_WDT_OFS         4'h8

// Control register fields
`define SWC_CTRL_WDT_EN     0
`define SWC_CTRL_WDT_SLP    1
`define SWC_CTRL_PINRST_EN  2
`define SWC_CTRL_BOR_EN     3
`define SWC_CTRL_TMR_LO     4
`define SWC_CTRL_TMR_HI     5
`define SWC_CTRL_ADC_RC     6
`define SWC_CTRL_RESET      32'h0000_0003

// Status register fields
`define SWC_STAT_TO_N       0
`define SWC_STAT_PD_N       1
`define SWC_STAT_ASLEEP     2
`define SWC_STAT_CAUSE_LO   3
`define SWC_STAT_CAUSE_HI   5

// Timing: low-frequency oscillator tick derived from the system clock
`define SWC_CLK_HZ          100000000
`define SWC_LF_OSC_HZ       31000
`define SWC_LF_DIV          (`SWC_CLK_HZ / `SWC_LF_OSC_HZ)
`define SWC_WDT_PRESCALE    32
`define SWC_WDT_LIMIT       1024

`endif

/* rtl/sleep_wakeup_pkg.sv */
`default_nettype none

package sleep_wakeup_pkg;

    typedef enum logic [2:0] {
        ST_AWAKE  = 3'b001,
        ST_ASLEEP = 3'b010,
        ST_WAKING = 3'b100
    } pwr_state_t;

    typedef enum logic [2:0] {
        CAUSE_NONE   = 3'h0,
        CAUSE_WDT    = 3'h1,
        CAUSE_IRQ    = 3'h2,
        CAUSE_PINRST = 3'h3,
        CAUSE_BOR    = 3'h4
    } wake_cause_t;

    typedef enum logic [1:0] {
        TMR_SYSCLK = 2'h0,
        TMR_LFOSC  = 2'h1,
        TMR_EXTCLK = 2'h2,
        TMR_OTHER  = 2'h3
    } tmr_src_t;

endpackage

`default_nettype wire

/* rtl/io_hold_latch.sv */
`timescale 1ns/100ps
`default_nettype none

module io_hold_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             hold,
    input  wire logic [WIDTH-1:0] d_out,
    input  wire logic [WIDTH-1:0] d_oe,
    output logic      [WIDTH-1:0] q_out,
    output logic      [WIDTH-1:0] q_oe
);

    // Reset leaves every pin released; hold freezes the last awake value
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            q_out <= '0;
            q_oe  <= '0;
        end
        else if (!hold)
        begin
            q_out <= d_out;
            q_oe  <= d_oe;
        end
    end

endmodule

`default_nettype wire

/* rtl/sleep_wakeup_control.sv */
// Overview of operation
// - Sleep entry clears watchdog; runs if sleep-enabled
// - Sleep entry clears power-down flag (active low)
// - Sleep entry sets time-out flag (active low)
// - CPU clock stopped while asleep
// - Low-frequency oscillator keeps running in sleep
// - Secondary timer runs asleep on LF/external clock
// - ADC runs asleep with RC conversion oscillator
// - I/O ports hold pre-sleep drive state
// - Only the watchdog reset is affected by sleep
// - Resets restart; watchdog and interrupts resume execution
// - Sleep prefetches instruction at PC plus one
// - Interrupt wakes if enabled, ignoring global enable
// - Wake executes next instruction, then vectors if enabled
// - Watchdog cleared on every watchdog or interrupt wake
// - Pending interrupt before sleep makes it a no-op
// - Interrupt during sleep completes sleep, wakes immediately
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wakeup_cfg.svh"

module sleep_wakeup_control
    import sleep_wakeup_pkg::*;
#(
    parameter int IRQ_N    = 8,
    parameter int PC_W     = 13,
    parameter int IO_W     = 8,
    parameter int WDT_PRE  = `SWC_WDT_PRESCALE,
    parameter int WDT_LIM  = `SWC_WDT_LIMIT
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    input  wire logic             sleep_req,
    input  wire logic             wdt_clear_req,
    input  wire logic [PC_W-1:0]  pc,
    input  wire logic [IRQ_N-1:0] irq_flags,
    input  wire logic [IRQ_N-1:0] irq_enable,
    input  wire logic             global_irq_enable,
    input  wire logic             master_clear_pin,
    input  wire logic             brownout_reset,
    input  wire logic [IO_W-1:0]  io_out_core,
    input  wire logic [IO_W-1:0]  io_oe_core,
    output logic      [IO_W-1:0]  io_out,
    output logic      [IO_W-1:0]  io_oe,
    output logic                  cpu_clk_en,
    output logic                  low_freq_osc,
    output logic                  secondary_timer_run,
    output logic                  adc_run,
    output logic      [PC_W-1:0]  prefetch_addr,
    output logic                  wake_resume,
    output logic                  resume_vector,
    output logic                  core_restart,
    output logic                  powerdown_flag_n,
    output logic                  timeout_flag_n
);

    localparam int LF_DIV = `SWC_LF_DIV;

    pwr_state_t  state_ff;
    pwr_state_t  nxt_state;
    wake_cause_t cause_ff;
    logic [31:0] ctrl_ff;
    logic [11:0] lf_div_ff;
    logic        lf_tick_ff;
    logic [15:0] wdt_pre_ff;
    logic [15:0] wdt_cnt_ff;
    logic        pd_n_ff;
    logic        to_n_ff;
    logic        wake_ff;
    logic        vector_ff;
    logic        restart_ff;
    logic [PC_W-1:0] prefetch_ff;
    logic [31:0] rdata_ff;

    logic        pending;
    logic        awake;
    logic        asleep;
    logic        enter;
    logic        wdt_run;
    logic        wdt_pre_wrap;
    logic        wdt_expire;
    logic        wdt_clear;
    logic        pinrst_hit;
    logic        bor_hit;
    logic        restart_req;
    tmr_src_t    tmr_src;

    assign awake   = (state_ff == ST_AWAKE);
    assign asleep  = (state_ff == ST_ASLEEP);
    // Per-source enables alone decide a wake; the global enable only steers vectoring
    assign pending = |(irq_flags & irq_enable);
    // A reset arriving with the sleep pulse wins, so the core is never parked mid-restart
    assign enter   = awake && sleep_req && !pending && !restart_req;
    assign tmr_src = tmr_src_t'(ctrl_ff[`SWC_CTRL_TMR_HI:`SWC_CTRL_TMR_LO]);

    assign pinrst_hit  = master_clear_pin && ctrl_ff[`SWC_CTRL_PINRST_EN];
    assign bor_hit     = brownout_reset && ctrl_ff[`SWC_CTRL_BOR_EN];
    // Sleep never masks these two; only the watchdog depends on the state
    assign restart_req = pinrst_hit || bor_hit || (awake && wdt_expire);

    // Low-frequency oscillator, free running regardless of power state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lf_div_ff  <= 12'h000;
            lf_tick_ff <= 1'b0;
        end
        else if (lf_div_ff == 12'(LF_DIV - 1))
        begin
            lf_div_ff  <= 12'h000;
            lf_tick_ff <= 1'b1;
        end
        else
        begin
            lf_div_ff  <= lf_div_ff + 12'h001;
            lf_tick_ff <= 1'b0;
        end
    end

    // Watchdog
    assign wdt_run      = ctrl_ff[`SWC_CTRL_WDT_EN] &&
                          (!asleep || ctrl_ff[`SWC_CTRL_WDT_SLP]);
    assign wdt_pre_wrap = wdt_run && lf_tick_ff && (wdt_pre_ff == 16'(WDT_PRE - 1));
    assign wdt_expire   = wdt_pre_wrap && (wdt_cnt_ff == 16'(WDT_LIM - 1));
    // Clearing takes priority over counting so entry and wake start from zero
    assign wdt_clear    = wdt_clear_req || enter || (state_ff == ST_WAKING) ||
                          wdt_expire || !ctrl_ff[`SWC_CTRL_WDT_EN];

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wdt_pre_ff <= 16'h0000;
            wdt_cnt_ff <= 16'h0000;
        end
        else if (wdt_clear)
        begin
            wdt_pre_ff <= 16'h0000;
            wdt_cnt_ff <= 16'h0000;
        end
        else if (wdt_run && lf_tick_ff)
        begin
            wdt_pre_ff <= wdt_pre_wrap ? 16'h0000 : wdt_pre_ff + 16'h0001;
            wdt_cnt_ff <= wdt_pre_wrap ? wdt_cnt_ff + 16'h0001 : wdt_cnt_ff;
        end
    end

    // Power state machine; wake inputs are all sampled on core_clk
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_AWAKE:
                if (enter)
                    nxt_state = ST_ASLEEP;
            ST_ASLEEP:
                if (restart_req)
                    nxt_state = ST_AWAKE;
                else if (pending || wdt_expire)
                    nxt_state = ST_WAKING;
            ST_WAKING:
                nxt_state = ST_AWAKE;
            default:
                nxt_state = ST_AWAKE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_ff <= ST_AWAKE;
        else
            state_ff <= nxt_state;
    end

    // Clock held off from the entry edge until the wake cycle
    assign cpu_clk_en = !asleep;

    // Status flags; power-on reset sets both high
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pd_n_ff <= 1'b1;
            to_n_ff <= 1'b1;
        end
        else if (wdt_expire)
        begin
            to_n_ff <= 1'b0;
        end
        else if (enter)
        begin
            pd_n_ff <= 1'b0;
            to_n_ff <= 1'b1;
        end
        else if (wdt_clear_req && awake)
        begin
            pd_n_ff <= 1'b1;
            to_n_ff <= 1'b1;
        end
    end

    assign powerdown_flag_n = pd_n_ff;
    assign timeout_flag_n   = to_n_ff;

    // Prefetch address captured with the sleep request
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            prefetch_ff <= '0;
        else if (awake && sleep_req)
            prefetch_ff <= pc + PC_W'(1);
    end

    assign prefetch_addr = prefetch_ff;

    // Resume and restart indications toward the core
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_ff    <= 1'b0;
            vector_ff  <= 1'b0;
            restart_ff <= 1'b0;
            cause_ff   <= CAUSE_NONE;
        end
        else
        begin
            wake_ff    <= (state_ff == ST_WAKING);
            // Core runs the prefetched instruction first, then vectors
            vector_ff  <= (state_ff == ST_WAKING) && global_irq_enable && pending;
            restart_ff <= restart_req;
            if (asleep && bor_hit)
                cause_ff <= CAUSE_BOR;
            else if (asleep && pinrst_hit)
                cause_ff <= CAUSE_PINRST;
            else if (asleep && wdt_expire)
                cause_ff <= CAUSE_WDT;
            else if (asleep && pending)
                cause_ff <= CAUSE_IRQ;
        end
    end

    assign wake_resume   = wake_ff;
    assign resume_vector = vector_ff;
    assign core_restart  = restart_ff;

    // Sleep-capable clock domains
    assign low_freq_osc        = lf_tick_ff;
    assign secondary_timer_run = !asleep || (tmr_src == TMR_LFOSC) ||
                                 (tmr_src == TMR_EXTCLK);
    assign adc_run             = !asleep || ctrl_ff[`SWC_CTRL_ADC_RC];

    io_hold_latch #(
        .WIDTH (IO_W)
    ) u_io_hold (
        .core_clk (core_clk),
        .rst      (rst),
        .hold     (asleep),
        .d_out    (io_out_core),
        .d_oe     (io_oe_core),
        .q_out    (io_out),
        .q_oe     (io_oe)
    );

    // Register bus
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            ctrl_ff <= `SWC_CTRL_RESET;
        else if (reg_wr && reg_addr == `SWC_CTRL_OFS)
            ctrl_ff <= {25'h000_0000, reg_wdata[6:0]};
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `SWC_CTRL_OFS:   rdata_ff <= ctrl_ff;
                `SWC_STATUS_OFS: rdata_ff <= {26'h000_0000, cause_ff, asleep, pd_n_ff, to_n_ff};
                `SWC_WDT_OFS:    rdata_ff <= {16'h0000, wdt_cnt_ff};
                default:         rdata_ff <= 32'h0000_0000;
            endcase
        end
        else
            rdata_ff <= 32'h0000_0000;
    end

    assign reg_rdata = rdata_ff;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_enter;
        awake && sleep_req && !pending && !pinrst_hit && !bor_hit && !wdt_expire;
    endsequence

    sequence s_wake_path;
        (state_ff == ST_WAKING) ##1 (awake && wake_resume);
    endsequence

    a_noop_pending: assert property (
        (awake && sleep_req && pending) |=> (awake && $stable(pd_n_ff) && $stable(to_n_ff)))
        else $error("sleep with pending interrupt was not a no-op");

    a_entry_flags: assert property (
        s_enter |=> (asleep && !powerdown_flag_n && timeout_flag_n))
        else $error("sleep entry flags wrong");

    a_entry_wdt_clear: assert property (
        s_enter |=> (wdt_cnt_ff == 16'h0000 && wdt_pre_ff == 16'h0000))
        else $error("watchdog not cleared on sleep entry");

    a_cpu_clock_gate: assert property (
        asleep |-> !cpu_clk_en)
        else $error("cpu clock running while asleep");

    a_irq_wake_path: assert property (
        (asleep && pending && !pinrst_hit && !bor_hit) |=> s_wake_path)
        else $error("enabled interrupt did not wake the core");

    a_wake_wdt_clear: assert property (
        (state_ff == ST_WAKING) |=> (wdt_cnt_ff == 16'h0000))
        else $error("watchdog not cleared on wake");

    a_io_hold_state: assert property (
        (asleep && $past(asleep)) |-> ($stable(io_out) && $stable(io_oe)))
        else $error("io state changed during sleep");

    a_timer_sleep_run: assert property (
        (asleep && tmr_src == TMR_LFOSC) |-> secondary_timer_run)
        else $error("secondary timer stopped in sleep");

    a_resume_vector: assert property (
        ((state_ff == ST_WAKING) && global_irq_enable && pending) |=> (resume_vector && wake_resume))
        else $error("vector not requested after wake");

    a_reset_restart: assert property (
        (pinrst_hit || bor_hit) |=> (core_restart && awake))
        else $error("enabled reset source did not restart");

    a_prefetch_addr: assert property (
        s_enter |=> (prefetch_addr == $past(pc) + PC_W'(1)))
        else $error("prefetch address is not pc plus one");

endmodule

`default_nettype wire

/* verif/core_model.sv */
`timescale 1ns/100ps
`default_nettype none

module core_model #(
    parameter int PC_W = 13
) (
    input  wire logic            core_clk,
    input  wire logic            cpu_clk_en,
    input  wire logic            wake_resume,
    input  wire logic            resume_vector,
    output logic                 sleep_req,
    output logic      [PC_W-1:0] pc
);
    int executed;
    int vectors;

    initial
    begin
        sleep_req = 1'b0;
        pc        = '0;
        executed  = 0;
        vectors   = 0;
    end

    // Only a running core clock lets instructions retire
    always @(posedge core_clk)
    begin
        if (cpu_clk_en)
            executed <= executed + 1;
        if (wake_resume && resume_vector)
            vectors <= vectors + 1;
    end

    // Pulses sleep_req for one cycle with pc set to the sleep instruction's address
    task automatic exec_sleep(input logic [PC_W-1:0] at);
        @(posedge core_clk);
        sleep_req <= 1'b1;
        pc        <= at;
        @(posedge core_clk);
        sleep_req <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* verif/sleep_wakeup_control_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module sleep_wakeup_control_tb_top
    import sleep_wakeup_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        wdt_clear_req = 1'b0;
    logic        glob_en = 1'b0;
    logic        clr_pin = 1'b0;
    logic        bor = 1'b0;
    logic [7:0]  irq_flags = 8'h00;
    logic [7:0]  irq_enable = 8'h00;
    logic [7:0]  io_out_core = 8'h00;
    logic [7:0]  io_oe_core = 8'h00;
    logic [31:0] reg_rdata;
    logic        sleep_req;
    logic [12:0] pc;
    logic [12:0] prefetch_addr;
    logic [7:0]  io_out;
    logic [7:0]  io_oe;
    logic        cpu_clk_en;
    logic        low_freq_osc;
    logic        tmr_run;
    logic        adc_run;
    logic        wake_resume;
    logic        resume_vector;
    logic        core_restart;
    logic        pd_n;
    logic        to_n;
    int          fails = 0;
    int          checks = 0;
    int          seed = 32'hd6f4;

    always #5 core_clk = ~core_clk;

    sleep_wakeup_control #(.WDT_PRE(2), .WDT_LIM(4)) u_dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
        .wdt_clear_req(wdt_clear_req), .pc(pc), .irq_flags(irq_flags),
        .irq_enable(irq_enable), .global_irq_enable(glob_en), .master_clear_pin(clr_pin),
        .brownout_reset(bor), .io_out_core(io_out_core), .io_oe_core(io_oe_core),
        .io_out(io_out), .io_oe(io_oe), .cpu_clk_en(cpu_clk_en),
        .low_freq_osc(low_freq_osc), .secondary_timer_run(tmr_run), .adc_run(adc_run),
        .prefetch_addr(prefetch_addr), .wake_resume(wake_resume),
        .resume_vector(resume_vector), .core_restart(core_restart),
        .powerdown_flag_n(pd_n), .timeout_flag_n(to_n)
    );

    core_model u_core (
        .core_clk(core_clk), .cpu_clk_en(cpu_clk_en), .wake_resume(wake_resume),
        .resume_vector(resume_vector), .sleep_req(sleep_req), .pc(pc)
    );

    function automatic logic tmr_exp(input logic [31:0] c);
        return (c[5:4] == 2'h1) || (c[5:4] == 2'h2);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    // Selector instead of a ref argument keeps free simulators happy
    function automatic logic pick(input int w);
        case (w)
            0: return wake_resume;
            1: return core_restart;
            2: return low_freq_osc;
            default: return cpu_clk_en;
        endcase
    endfunction

    task automatic wait_hi(input int w, input int lim);
        int n;
        n = 0;
        while (pick(w) !== 1'b1 && n < lim)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic stop_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bound sits near 90000 cycles, well above the slow watchdog wake
    initial
    begin
        #900000;
        fails++;
        stop_test();
    end

    initial
    begin
        logic [31:0] d;
        logic [31:0] ctrl;
        logic [12:0] p;
        logic [7:0]  ho;
        logic [7:0]  he;
        int          k;
        int          n;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        tick(1);
        chk({pd_n, to_n, cpu_clk_en}, 3'b111);
        rd(4'h0, d);
        chk(d, 32'h0000_0003);
        wr(4'hC, 32'hFFFF_FFFF);
        rd(4'hC, d);
        chk(d, 32'h0000_0000);
        $display("test reset done");

        // Enabled flag already set with global enable off
        wr(4'h0, 32'h0000_0000);
        @(posedge core_clk);
        irq_flags  <= 8'h01;
        irq_enable <= 8'h01;
        u_core.exec_sleep(13'h0100);
        #1;
        chk({cpu_clk_en, pd_n, to_n}, 3'b111);
        @(posedge core_clk);
        irq_flags  <= 8'h00;
        irq_enable <= 8'h00;
        $display("test noop done");

        for (int i = 0; i < 8; i++)
        begin
            ctrl = (i == 0) ? 32'h0000_0003 : ($random(seed) & 32'h0000_007C);
            p    = 13'($random(seed));
            ho   = 8'($random(seed));
            he   = 8'($random(seed));
            k    = {$random(seed)} % 8;
            wr(4'h0, ctrl);
            @(posedge core_clk);
            io_out_core <= ho;
            io_oe_core  <= he;
            glob_en     <= i[0];
            u_core.exec_sleep(p);
            #1;
            chk(cpu_clk_en, 1'b0);
            chk(pd_n, 1'b0);
            chk(to_n, 1'b1);
            chk(prefetch_addr, 13'(p + 13'h0001));
            chk(tmr_run, tmr_exp(ctrl));
            chk(adc_run, ctrl[6]);
            if (i == 0)
            begin
                rd(4'h8, d);
                chk(d[15:0], 16'h0000);
            end
            @(posedge core_clk);
            io_out_core  <= ~ho;
            io_oe_core   <= ~he;
            irq_flags[k] <= 1'b1;
            n = u_core.executed;
            tick(4);
            chk(u_core.executed, n);
            chk({io_out, io_oe}, {ho, he});
            chk(cpu_clk_en, 1'b0);
            @(posedge core_clk);
            irq_enable[k] <= 1'b1;
            wait_hi(0, 6);
            chk(wake_resume, 1'b1);
            chk(resume_vector, i[0]);
            rd(4'h4, d);
            chk(d[5:0], {CAUSE_IRQ, 3'b001});
            if (i == 0)
            begin
                rd(4'h8, d);
                chk(d[15:0], 16'h0000);
            end
            @(posedge core_clk);
            irq_flags  <= 8'h00;
            irq_enable <= 8'h00;
        end
        chk(u_core.vectors, 32'h0000_0004);
        $display("test irq wake done");

        for (int r = 0; r < 2; r++)
        begin
            wr(4'h0, r ? 32'h0000_0008 : 32'h0000_0004);
            u_core.exec_sleep(13'h0010);
            @(posedge core_clk);
            clr_pin <= (r == 1);
            bor     <= (r == 0);
            tick(4);
            chk(cpu_clk_en, 1'b0);
            @(posedge core_clk);
            clr_pin <= (r == 0);
            bor     <= (r == 1);
            wait_hi(1, 4);
            chk({core_restart, cpu_clk_en}, 2'b11);
            rd(4'h4, d);
            chk(d[5:3], r ? CAUSE_BOR : CAUSE_PINRST);
            @(posedge core_clk);
            clr_pin <= 1'b0;
            bor     <= 1'b0;
            tick(2);
        end
        $display("test reset wake done");

        wr(4'h0, 32'h0000_0003);
        u_core.exec_sleep(13'h0020);
        tick(1);
        wait_hi(2, 4000);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (low_freq_osc !== 1'b1 && n < 4000);
        chk(n, 3225);
        wait_hi(3, 40000);
        chk(cpu_clk_en, 1'b1);
        tick(2);
        rd(4'h4, d);
        chk({d[5:3], d[0]}, {CAUSE_WDT, 1'b0});
        rd(4'h8, d);
        chk(d[15:0], 16'h0000);
        @(posedge core_clk);
        wdt_clear_req <= 1'b1;
        @(posedge core_clk);
        wdt_clear_req <= 1'b0;
        #1;
        chk({pd_n, to_n}, 2'b11);
        $display("test watchdog wake done");
        stop_test();
    end
endmodule

`default_nettype wire
